/* File: include/ilim_cfg_defs.vh */
// Constants for the channel current limit configuration block.
// Assumes a register port of address, write strobe and 16-bit data.
`ifndef ILIM_CFG_DEFS_VH
`define ILIM_CFG_DEFS_VH
`define CLIM_CFG_ADDR     6'h0f
`define FAULT_STATUS_ADDR 6'h0c
`define CLIM_CFG_RESET    16'h0088
`define CHG_MODE_HI       13
`define CHG_MODE_LO       12
`define HEAT_EN_BIT       11
`define WIN_HI            10
`define WIN_LO            8
`define START_HI          7
`define START_LO          4
`define STEADY_HI         3
`define STEADY_LO         0
`define OC_FLAG_BIT       4
`define CHG_MODE_TRIP     2'h0
`define CHG_MODE_REG      2'h2
`define START_MAX_TRIP    4'ha
`define START_MAX_REG     4'hc
`define STEADY_MAX        4'ha
`define CLK_KHZ           50000
`define TICKS_PER_MS      (`CLK_KHZ)
`endif

/* File: hw/startup_window_timer.v */
// Startup window timer: counts the programmed window from channel turn-on.
// Assumes a one-cycle turn-on pulse on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "ilim_cfg_defs.vh"
module startup_window_timer #(
  parameter TICKS_PER_MS = `TICKS_PER_MS
) (
  input  wire       clk,       // System clock
  input  wire       rst_n,     // Async reset, active low
  input  wire       start,     // Turn-on pulse
  input  wire       stop,      // Channel off
  input  wire [2:0] win_code,  // Window length code
  output reg        active_q   // Window running
);
  reg [6:0]  ms_left_q;
  reg [16:0] tick_q;

  function [6:0] win_ms;
    input [2:0] c;
    begin
      case (c)
        3'h0: win_ms = 7'd0;
        3'h1: win_ms = 7'd2;
        3'h2: win_ms = 7'd4;
        3'h3: win_ms = 7'd6;
        3'h4: win_ms = 7'd10;
        3'h5: win_ms = 7'd20;
        3'h6: win_ms = 7'd50;
        default: win_ms = 7'd100;
      endcase
    end
  endfunction

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_q  <= 1'b0;
      ms_left_q <= 7'd0;
      tick_q    <= 17'd0;
    end else if (stop) begin
      active_q <= 1'b0;
    end else if (start) begin
      ms_left_q <= win_ms(win_code);
      active_q  <= (win_ms(win_code) != 7'd0);
      tick_q    <= 17'd0;
    end else if (active_q) begin
      if (tick_q == TICKS_PER_MS - 1) begin
        tick_q <= 17'd0;
        if (ms_left_q == 7'd1)
          active_q <= 1'b0;
        ms_left_q <= ms_left_q - 7'd1;
      end else begin
        tick_q <= tick_q + 17'd1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/current_limit_config_ch1.v */
// Channel 1 current limit configuration register and inrush/trip control.
// Assumes a same-clock register port and comparator flags from the analog side.
`timescale 1ns/10ps
`default_nettype none
`include "ilim_cfg_defs.vh"
module current_limit_config_ch1 #(
  parameter TICKS_PER_MS = `TICKS_PER_MS
) (
  input  wire        clk,            // System clock
  input  wire        rst_n,          // Async reset, active low
  input  wire [5:0]  reg_addr,       // Register address
  input  wire        reg_wr,         // Write strobe
  input  wire        reg_rd,         // Read strobe
  input  wire [15:0] reg_wdata,      // Write data
  output reg  [15:0] reg_rdata_q,    // Read data
  input  wire        ch_on,          // Channel on request (pin domain)
  input  wire        pulse_req,      // Pulse mode requested
  input  wire        over_level,     // Current at or above selected level (pin)
  input  wire        thermal_sd,     // Thermal shutdown (pin)
  input  wire        output_charged, // Output fully charged (pin)
  output reg         ch_drive_q,     // Switch gate enable
  output reg         regulate_q,     // Current-limit regulation active
  output reg  [3:0]  level_code_q,   // Threshold code to comparator
  output reg         level_is_reg_q, // Level uses regulation table
  output reg         pulse_allow_q,  // Pulse mode permitted
  output reg         heat_calc_q,    // Wire heating calculation running
  output reg         window_q,       // Startup window running
  output reg         oc_fault_q      // Overcurrent fault flag
);
  reg [15:0] cfg_q;
  reg [1:0]  on_s_q, ov_s_q, th_s_q, ch_s_q;
  reg        on_prev_q;
  reg        tripped_q;
  reg        charged_q;
  wire       on_sync   = on_s_q[1];
  wire       ov_sync   = ov_s_q[1];
  wire       th_sync   = th_s_q[1];
  wire       chg_sync  = ch_s_q[1];
  wire       turn_on   = on_sync & ~on_prev_q;
  wire       win_act;
  wire [1:0] chg_mode  = cfg_q[`CHG_MODE_HI:`CHG_MODE_LO];
  wire       mode_trip = (chg_mode == `CHG_MODE_TRIP);
  wire       mode_reg  = (chg_mode == `CHG_MODE_REG);
  wire       trip_now;

  startup_window_timer #(.TICKS_PER_MS(TICKS_PER_MS)) u_timer (
    .clk      (clk),
    .rst_n    (rst_n),
    .start    (turn_on),
    .stop     (~on_sync),
    .win_code (cfg_q[`WIN_HI:`WIN_LO]),
    .active_q (win_act)
  );

  // Inputs from the analog side are asynchronous: two stages each
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      on_s_q <= 2'b00;
      ov_s_q <= 2'b00;
      th_s_q <= 2'b00;
      ch_s_q <= 2'b00;
    end else begin
      on_s_q <= {on_s_q[0], ch_on};
      ov_s_q <= {ov_s_q[0], over_level};
      th_s_q <= {th_s_q[0], thermal_sd};
      ch_s_q <= {ch_s_q[0], output_charged};
    end
  end

  // Regulation mode never trips during the window; it limits instead
  assign trip_now = ch_drive_q & ov_sync & ~(win_act & mode_reg);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q       <= `CLIM_CFG_RESET;
      reg_rdata_q <= 16'h0000;
      oc_fault_q  <= 1'b0;
      on_prev_q   <= 1'b0;
      tripped_q   <= 1'b0;
      charged_q   <= 1'b0;
    end else begin
      on_prev_q <= on_sync;
      if (reg_wr && reg_addr == `CLIM_CFG_ADDR)
        cfg_q <= reg_wdata;
      if (reg_rd && reg_addr == `CLIM_CFG_ADDR)
        reg_rdata_q <= cfg_q;
      else if (reg_rd && reg_addr == `FAULT_STATUS_ADDR)
        reg_rdata_q <= {11'h000, oc_fault_q, 4'h0};
      else if (reg_rd)
        reg_rdata_q <= 16'h0000;
      // Set wins over the read clear; clear only once condition gone
      if (trip_now)
        oc_fault_q <= 1'b1;
      else if (reg_rd && reg_addr == `FAULT_STATUS_ADDR && !ov_sync)
        oc_fault_q <= 1'b0;
      // A trip holds the switch off until the next turn-on request
      if (!on_sync)
        tripped_q <= 1'b0;
      else if (trip_now)
        tripped_q <= 1'b1;
      if (turn_on)
        charged_q <= 1'b0;
      else if (chg_sync)
        charged_q <= 1'b1;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ch_drive_q     <= 1'b0;
      regulate_q     <= 1'b0;
      level_code_q   <= 4'h0;
      level_is_reg_q <= 1'b0;
      pulse_allow_q  <= 1'b0;
      heat_calc_q    <= 1'b0;
      window_q       <= 1'b0;
    end else begin
      window_q   <= win_act;
      // Unsupported modes fall back to off rather than guessing a behaviour
      ch_drive_q <= on_sync & ~tripped_q & ~trip_now & (mode_trip | mode_reg);
      // Regulate in the window until charged; also off while thermal shutdown is asserted
      regulate_q <= on_sync & win_act & mode_reg & ~charged_q & ~chg_sync
                    & ~th_sync;
      if (win_act) begin
        level_code_q   <= cfg_q[`START_HI:`START_LO];
        level_is_reg_q <= mode_reg;
      end else begin
        level_code_q   <= cfg_q[`STEADY_HI:`STEADY_LO];
        level_is_reg_q <= 1'b0;
      end
      pulse_allow_q <= pulse_req & mode_trip & ~win_act;
      heat_calc_q   <= cfg_q[`HEAT_EN_BIT] & on_sync & ~turn_on
                       & ~win_act & ~tripped_q;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/clim_props.sv */
// Checks on the current limit block ports.
// Assumes config changes only by register writes.
`timescale 1ns/10ps
`default_nettype none
module clim_props (
  input wire logic        clk, rst_n, reg_wr, reg_rd, over_level, ch_drive_q,
  input wire logic        regulate_q, heat_calc_q, pulse_allow_q, window_q, oc_fault_q,
  input wire logic [5:0]  reg_addr,
  input wire logic [3:0]  level_code_q,
  input wire logic [15:0] reg_wdata, reg_rdata_q
);
  logic [15:0] cfg_q;
  wire         rd_flt = reg_rd && reg_addr == 6'h0c;
  wire         trip = ch_drive_q && !regulate_q && over_level;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) cfg_q <= 16'h0088;
    else if (reg_wr && reg_addr == 6'h0f) cfg_q <= reg_wdata;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  cfg_read_a: assert property (reg_rd && reg_addr == 6'h0f |=> reg_rdata_q == $past(cfg_q))
    else $error("config read differs");
  trip_set_a: assert property (trip [*2] |-> ##[0:4] oc_fault_q)
    else $error("no trip");
  trip_off_a: assert property ($rose(oc_fault_q) |-> ##[0:1] !ch_drive_q)
    else $error("drive kept on");
  fault_hold_a: assert property (oc_fault_q && !rd_flt |=> oc_fault_q)
    else $error("flag lost");
  window_entry_a: assert property ($rose(window_q) |-> !heat_calc_q && !pulse_allow_q)
    else $error("window entry");
  heat_enable_a: assert property (heat_calc_q |-> $past(cfg_q[11]))
    else $error("heat enable");
  regulate_mode_a: assert property (regulate_q |-> $past(cfg_q[13:12]) == 2'h2)
    else $error("regulate mode");
  pulse_mode_a: assert property (pulse_allow_q |-> $past(cfg_q[13:12]) == 2'h0)
    else $error("pulse mode");
  level_pick_a: assert property ($past(rst_n) |-> level_code_q == (window_q ?
    $past(cfg_q[7:4]) : $past(cfg_q[3:0])))
    else $error("level code");
  cover property ($rose(oc_fault_q));
  cover property ($fell(window_q) && ch_drive_q);
  cover property ($fell(regulate_q) && ch_drive_q);
endmodule
bind current_limit_config_ch1 clim_props props_i (.clk, .rst_n, .reg_wr, .reg_rd, .over_level,
  .ch_drive_q, .regulate_q, .heat_calc_q, .pulse_allow_q, .window_q, .oc_fault_q, .reg_addr,
  .level_code_q, .reg_wdata, .reg_rdata_q);
`default_nettype wire

/* File: testbench/host_model.sv */
// Host controller model on the register port.
// Assumes calls from bench processes; launches at falling edges.
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic        clk,       // Clock
  output var  logic [5:0]  reg_addr,  // Address
  output var  logic        reg_wr,    // Write strobe
  output var  logic        reg_rd,    // Read strobe
  output var  logic [15:0] reg_wdata  // Write data
);
  initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 24'h0;
  // Unparalleled use, so codes above 8h may be sent
  task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] d);
    @(negedge clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(negedge clk);
    {reg_wr, reg_rd, reg_wdata} = {2'b00, ~d};
  endtask
endmodule
`default_nettype wire

/* File: testbench/current_limit_config_ch1_tb.sv */
// Bench for the current limit block with a host model.
// Assumes a shortened millisecond tick.
`timescale 1ns/10ps
`default_nettype none
module current_limit_config_ch1_tb;
  localparam int TK = 10;
  logic clk = 0, rst_n = 0, ch_on = 0, over_level = 0, output_charged = 0;
  logic thermal_sd = 0, pulse_req = 1;
  wire [5:0] reg_addr;
  wire reg_wr, reg_rd, ch_drive_q, regulate_q, level_is_reg_q, pulse_allow_q, heat_calc_q;
  wire window_q, oc_fault_q;
  wire [15:0] reg_wdata, reg_rdata_q;
  wire [3:0] level_code_q;
  wire [7:0] in_win = {regulate_q, level_is_reg_q, heat_calc_q, pulse_allow_q, level_code_q};
  wire [6:0] after_win = {ch_drive_q, heat_calc_q, pulse_allow_q, level_code_q};
  int num_errors = 0, comparisons = 0, seed = 32'h74193c83, cfg = 'h88, n;
  int ms[8] = '{0, 2, 4, 6, 10, 20, 50, 100};
  always #10 clk = ~clk;
  host_model host (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
  current_limit_config_ch1 #(.TICKS_PER_MS(TK)) dut (.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata_q, .ch_on, .pulse_req, .over_level, .thermal_sd,
    .output_charged, .ch_drive_q, .regulate_q, .level_code_q, .level_is_reg_q, .pulse_allow_q,
    .heat_calc_q, .window_q, .oc_fault_q);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wait_n(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    host.acc(1'b0, a, 16'h0);
    chk(reg_rdata_q, exp);
  endtask
  task automatic start(input logic [1:0] m, input logic [2:0] w);
    cfg = {2'($random(seed)), m, 1'b1, w, 8'h39};
    host.acc(1'b1, 6'h0f, cfg[15:0]);
    @(negedge clk) ch_on = 1;
  endtask
  task automatic stop;
    @(negedge clk) ch_on = 0;
    wait_n(6);
  endtask
  task automatic run(input logic [1:0] m, input logic [2:0] w);
    pulse_req = 1'($random(seed));
    start(m, w);
    n = 0;
    repeat (ms[w] * TK + 12) begin
      @(negedge clk);
      n += window_q;
      if (window_q) chk(in_win, {m == 2, m == 2, 6'h03});
    end
    chk(16'(n), 16'(ms[w] * TK));
    if (m[0]) chk(ch_drive_q, 1'b0);
    else chk(after_win, {2'b11, m == 0 && pulse_req, 4'h9});
    stop;
  endtask
  initial begin
    wait_n(12);
    rst_n = 1;
    rd(6'h0f, 16'h0088);
    repeat (3) begin
      cfg = $random(seed);
      host.acc(1'b1, 6'h0f, cfg[15:0]);
      rd(6'h0f, cfg[15:0]);
    end
    host.acc(1'b1, 6'h0c, 16'hffff);
    rd(6'h0c, 16'h0);
    rd(6'h3f, 16'h0);
    for (int m = 0; m < 4; m++)
      for (int w = 0; w < 8; w++)
        if (m % 2 == 0 || w == 0) run(m[1:0], w[2:0]);
    start(2'd0, 3'd3);
    wait_n(8);
    over_level = 1;
    wait_n(6);
    chk({ch_drive_q, oc_fault_q}, 2'b01);
    rd(6'h0c, 16'h0010);
    over_level = 0;
    wait_n(4);
    rd(6'h0c, 16'h0010);
    rd(6'h0c, 16'h0);
    stop;
    start(2'd2, 3'd7);
    wait_n(10);
    over_level = 1;
    wait_n(10);
    chk({ch_drive_q, regulate_q, oc_fault_q}, 3'b110);
    over_level = 0;
    wait_n(5);
    thermal_sd = 1;
    wait_n(6);
    chk(regulate_q, 1'b0);
    thermal_sd = 0;
    wait_n(6);
    chk(regulate_q, 1'b1);
    output_charged = 1;
    wait_n(6);
    chk(regulate_q, 1'b0);
    stop;
    output_charged = 0;
    tally_and_finish;
  end
  initial begin
    wait_n(20000);
    num_errors++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
